// file: hwp_top.sv
// Host write port: bus target, on-chip write queue and memory overflow queue.
// Assumes overflow storage answers fills in order and after earlier spills.
`timescale 1ns/10ps
module hwp_top (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic pci_clk,
  input wire logic pci_frame_n,
  input wire logic pci_irdy_n,
  input wire logic [31:0] pci_ad,
  input wire logic [3:0] pci_cbe_n,
  output logic pci_devsel_n_o,
  output logic pci_devsel_oe,
  output logic pci_trdy_n_o,
  output logic pci_trdy_oe,
  output logic pci_stop_n_o,
  output logic pci_stop_oe,
  input wire logic [7:0] win_base,
  input wire logic lfb_via_pipe,
  input wire logic [3:0] lfb_fmt,
  input wire logic fb_4mb,
  input wire logic [1:0] tex_size,
  input wire logic ovf_en,
  input wire logic [16:0] ovf_depth,
  output logic out_valid,
  input wire logic out_ready,
  output logic [1:0] out_region,
  output logic [21:0] out_addr,
  output logic [31:0] out_data,
  output logic [3:0] out_be,
  output logic out_to_pipe,
  output logic [3:0] out_lfb_fmt,
  output logic spill_valid,
  input wire logic spill_ready,
  output logic [15:0] spill_index,
  output logic [hwp_pkg::HWP_ENT_W-1:0] spill_data,
  output logic fill_req,
  output logic [15:0] fill_index,
  input wire logic fill_valid,
  input wire logic [hwp_pkg::HWP_ENT_W-1:0] fill_data
);
  import hwp_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [HWP_SYNC_N-1:0] clk_s;  // Bus clock synchroniser.
    logic [HWP_SYNC_N-1:0] frame_s;  // Frame synchroniser.
    logic [HWP_SYNC_N-1:0] irdy_s;  // Initiator ready synchroniser.
    logic [HWP_SYNC_N-1:0][31:0] ad_s;  // Address/data synchroniser.
    logic [HWP_SYNC_N-1:0][3:0] cbe_s;  // Command/enable synchroniser.
    logic frame_h, irdy_h;  // Frame and initiator ready as they stood before the counted edge.
    logic [31:0] ad_h;  // Address/data held from the low phase of the bus clock.
    logic [3:0] cbe_h;  // Command/enables held from the low phase of the bus clock.
    logic clk_lvl;  // Accepted bus clock level.
    logic frame_prev;  // Frame asserted at the previous bus edge.
    hwp_pst_type pst;  // Target state.
    logic [21:0] waddr;  // Current word offset in the window.
    logic devsel_n, trdy_n, stop_n, oe;  // Target control pins.
    logic [HWP_AW-1:0] wptr, rptr;  // Queue pointers.
    logic [7:0] cnt;  // Queue occupancy.
    logic head_v;  // Read data of the queue holds an unused entry.
    logic out_v;  // Output stage full.
    logic [1:0] out_rgn;
    logic [21:0] out_addr;
    logic [31:0] out_data;
    logic [3:0] out_be, out_fmt;
    logic out_pipe;
    logic spill_v;  // Spill write waiting for acceptance.
    logic [HWP_ENT_W-1:0] spill_d;
    logic [15:0] ovf_wp, ovf_rp;  // Overflow ring pointers.
    logic [16:0] ovf_cnt;  // Entries held in memory.
    logic fill_req, fill_pend;  // Fill request pulse and outstanding fill.
  } hwp_state_type;

  hwp_state_type st_r, st_nxt;
  logic push, pop, pedge, beat, room, go_direct, go_spill;
  logic [HWP_ENT_W-1:0] head_d;
  logic [16:0] ovf_lim;

  // ****************************************************************
  // Queue memory
  // ****************************************************************
  hwp_ram #(.W(HWP_ENT_W), .AW(HWP_AW)) hwp_ram_i (
    .clk_sys(clk_sys),
    .wr_en(push),
    .wr_addr(st_r.wptr),
    .wr_data({st_r.waddr, st_r.ad_h, ~st_r.cbe_h}),
    .rd_en(pop),
    .rd_addr(st_r.rptr),
    .rd_data_r(head_d)
  );

  // Masks a word offset to installed memory; registers pass unchanged.
  function automatic logic [21:0] hwp_offs(input logic [21:0] a, input logic big, input logic [1:0] ts);
    logic [21:0] m;
    m = 22'h3f_ffff;
    if (a[21]) begin
      unique case (ts)
        2'h0: m = HWP_TEX_2MB;
        2'h1: m = HWP_TEX_4MB;
        default: m = HWP_TEX_8MB;
      endcase
      hwp_offs = {1'b1, a[20:0] & m[20:0]};
    end else if (a[21:20] == HWP_RGN_LFB) begin
      m = big ? HWP_LFB_4MB : HWP_LFB_2MB;
      hwp_offs = {a[21:20], a[19:0] & m[19:0]};
    end else begin
      hwp_offs = a;
    end
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  // Samples the bus on accepted clock edges and drains the queues.
  always_comb begin
    st_nxt = st_r;
    st_nxt.fill_req = 1'b0;
    st_nxt.clk_s = {st_r.clk_s[1:0], pci_clk};
    st_nxt.frame_s = {st_r.frame_s[1:0], pci_frame_n};
    st_nxt.irdy_s = {st_r.irdy_s[1:0], pci_irdy_n};
    st_nxt.ad_s = {st_r.ad_s[1:0], pci_ad};
    st_nxt.cbe_s = {st_r.cbe_s[1:0], pci_cbe_n};
    // The initiator may change its pins right after a rising bus edge, so the
    // values used at that edge are the last ones seen while the clock was low.
    if (!st_r.clk_s[2]) begin
      st_nxt.frame_h = st_r.frame_s[2];
      st_nxt.irdy_h = st_r.irdy_s[2];
      st_nxt.ad_h = st_r.ad_s[2];
      st_nxt.cbe_h = st_r.cbe_s[2];
    end
    // A rising bus edge counts once the last two stages agree on a new high level.
    pedge = (st_r.clk_s[1] == st_r.clk_s[2]) && (st_r.clk_s[2] != st_r.clk_lvl) && st_r.clk_s[2];
    if (st_r.clk_s[1] == st_r.clk_s[2]) begin
      st_nxt.clk_lvl = st_r.clk_s[2];
    end
    beat = pedge && (st_r.pst == HWP_DATA) && !st_r.irdy_h && !st_r.trdy_n;
    push = beat;
    ovf_lim = (ovf_depth > HWP_OVF_MAX) ? HWP_OVF_MAX : ovf_depth;

    // Output stage and fill return; a fill always lands in an empty stage.
    if (st_r.out_v && out_ready) begin
      st_nxt.out_v = 1'b0;
    end
    go_direct = st_r.head_v && (st_r.ovf_cnt == 17'h0_0000) && !st_r.fill_pend && !st_r.spill_v
      && (!st_r.out_v || out_ready);
    go_spill = st_r.head_v && !go_direct && ovf_en && (!st_r.spill_v || spill_ready)
      && ((st_r.ovf_cnt + {16'h0000, st_r.spill_v && spill_ready}) < ovf_lim);
    if (go_direct || fill_valid) begin
      st_nxt.out_v = 1'b1;
      st_nxt.out_addr = hwp_offs(fill_valid ? fill_data[57:36] : head_d[57:36], fb_4mb, tex_size);
      st_nxt.out_data = fill_valid ? fill_data[35:4] : head_d[35:4];
      st_nxt.out_be = fill_valid ? fill_data[3:0] : head_d[3:0];
      st_nxt.out_rgn = st_nxt.out_addr[21] ? HWP_RGN_TEX : st_nxt.out_addr[21:20];
      st_nxt.out_pipe = (st_nxt.out_rgn == HWP_RGN_LFB) && lfb_via_pipe;
      st_nxt.out_fmt = lfb_fmt;
    end

    // Overflow ring: spill writes and fill requests.
    if (st_r.spill_v && spill_ready) begin
      st_nxt.spill_v = 1'b0;
      st_nxt.ovf_wp = (st_r.ovf_wp == ovf_lim[15:0] - 16'h0001) ? 16'h0000 : st_r.ovf_wp + 16'h0001;
    end
    if (go_spill) begin
      st_nxt.spill_v = 1'b1;
      st_nxt.spill_d = head_d;
    end
    if (st_r.ovf_cnt != 17'h0_0000 && !st_r.fill_pend && !st_r.out_v) begin
      st_nxt.fill_req = 1'b1;
      st_nxt.fill_pend = 1'b1;
    end
    // The read index stays on the requested slot until its answer arrives.
    if (fill_valid) begin
      st_nxt.fill_pend = 1'b0;
      st_nxt.ovf_rp = (st_r.ovf_rp == ovf_lim[15:0] - 16'h0001) ? 16'h0000 : st_r.ovf_rp + 16'h0001;
    end
    st_nxt.ovf_cnt = st_r.ovf_cnt + {16'h0000, st_r.spill_v && spill_ready} - {16'h0000, fill_valid};

    // Queue head: fetch a new entry when the old one has gone.
    if (go_direct || go_spill) begin
      st_nxt.head_v = 1'b0;
    end
    pop = (st_r.cnt != 8'h00) && (!st_r.head_v || go_direct || go_spill);
    if (pop) begin
      st_nxt.head_v = 1'b1;
      st_nxt.rptr = st_r.rptr + 7'h01;
    end
    if (push) begin
      st_nxt.wptr = st_r.wptr + 7'h01;
    end
    st_nxt.cnt = st_r.cnt + {7'h00, push} - {7'h00, pop};
    room = st_nxt.cnt < HWP_DEPTH;

    // Target state machine; it never drives frame or address.
    if (pedge) begin
      st_nxt.frame_prev = !st_r.frame_h;
      unique case (st_r.pst)
        HWP_IDLE: begin
          // Only memory writes in our window are claimed.
          if (!st_r.frame_h && !st_r.frame_prev && (st_r.ad_h[31:HWP_WIN_LSB] == win_base)
              && (st_r.cbe_h == HWP_CMD_MEM_WR || st_r.cbe_h == HWP_CMD_MEM_WRI)) begin
            st_nxt.pst = HWP_DATA;
            st_nxt.waddr = st_r.ad_h[23:2];
            st_nxt.oe = 1'b1;
            st_nxt.devsel_n = 1'b0;
            st_nxt.trdy_n = !room;
            st_nxt.stop_n = room;
          end
        end
        HWP_DATA: begin
          if (beat) begin
            st_nxt.waddr = st_r.waddr + 22'h00_0001;
          end
          if (!st_r.irdy_h && (!st_r.trdy_n || !st_r.stop_n) && st_r.frame_h) begin
            // Last phase done: drive inactive once, then release.
            st_nxt.pst = HWP_TURN;
            st_nxt.devsel_n = 1'b1;
            st_nxt.trdy_n = 1'b1;
            st_nxt.stop_n = 1'b1;
          end else if (beat && !room) begin
            st_nxt.trdy_n = 1'b1;
            st_nxt.stop_n = 1'b0;
          end
        end
        HWP_TURN: begin
          st_nxt.oe = 1'b0;
          st_nxt.pst = HWP_IDLE;
        end
      endcase
    end
  end

  // Registers the whole state.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_r <= '0;
      st_r.clk_s <= 3'h7;
      st_r.frame_s <= 3'h7;
      st_r.irdy_s <= 3'h7;
      st_r.frame_h <= 1'b1;
      st_r.irdy_h <= 1'b1;
      st_r.clk_lvl <= 1'b1;
      st_r.pst <= HWP_IDLE;
      st_r.devsel_n <= 1'b1;
      st_r.trdy_n <= 1'b1;
      st_r.stop_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign pci_devsel_n_o = st_r.devsel_n;
  assign pci_trdy_n_o = st_r.trdy_n;
  assign pci_stop_n_o = st_r.stop_n;
  assign pci_devsel_oe = st_r.oe;
  assign pci_trdy_oe = st_r.oe;
  assign pci_stop_oe = st_r.oe;
  assign out_valid = st_r.out_v;
  assign out_region = st_r.out_rgn;
  assign out_addr = st_r.out_addr;
  assign out_data = st_r.out_data;
  assign out_be = st_r.out_be;
  assign out_to_pipe = st_r.out_pipe;
  assign out_lfb_fmt = st_r.out_fmt;
  assign spill_valid = st_r.spill_v;
  assign spill_index = st_r.ovf_wp;
  assign spill_data = st_r.spill_d;
  assign fill_req = st_r.fill_req;
  assign fill_index = st_r.ovf_rp;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  a_io_unclaimed: assert property (pedge && st_r.pst == HWP_IDLE && st_r.cbe_h[3:1] == 3'h1
    |=> st_r.pst == HWP_IDLE) else $error("I/O cycle claimed");
  a_window_only: assert property ($rose(st_r.pst == HWP_DATA)
    |-> $past(st_r.ad_h[31:24]) == win_base) else $error("Claim outside window");
  a_zero_wait: assert property ($rose(st_r.pst == HWP_DATA) && $past(st_r.cnt) < 8'h7f
    |-> !pci_trdy_n_o && !pci_devsel_n_o) else $error("Wait state inserted");
  a_queue_bound: assert property (st_r.cnt <= HWP_DEPTH) else $error("Queue overrun");
  a_total_bound: assert property ({9'h000, st_r.cnt} + st_r.ovf_cnt <= HWP_TOTAL_MAX)
    else $error("Total queue overrun");
  a_full_stall: assert property (st_r.cnt == HWP_DEPTH |-> pci_trdy_n_o) else $error("Ready while full");
  a_stop_held: assert property (!pci_stop_n_o && st_r.pst == HWP_DATA && !pedge |=> !pci_stop_n_o)
    else $error("Stop dropped early");
  a_beat_queued: assert property (beat |=> st_r.cnt == $past(st_r.cnt) + 8'h01 - {7'h00, $past(pop)})
    else $error("Beat lost");
  a_tex_region: assert property (out_valid && out_region == HWP_RGN_TEX |-> out_addr[21])
    else $error("Texture region decode");
  a_lfb_route: assert property (out_valid && out_region != HWP_RGN_LFB |-> !out_to_pipe)
    else $error("Bad pipeline route");
  a_fb_mask: assert property (out_valid && out_region == HWP_RGN_LFB && !fb_4mb |-> !out_addr[19])
    else $error("Frame buffer mask");
  a_tex_mask: assert property (out_valid && out_region == HWP_RGN_TEX && tex_size == 2'h0
    |-> out_addr[20:19] == 2'h0) else $error("Texture mask");
  a_edge_gap: assert property (pedge |=> !pedge) else $error("Edges too close");

endmodule  // hwp_top

// file: hwp_pkg.sv
// Constants and types for the host write port of the graphics accelerator.
// Assumes a single 200 MHz system clock; bus pins arrive asynchronous to it.
package hwp_pkg;

  // ****************************************************************
  // Bus command and window decode
  // ****************************************************************
  localparam logic [3:0] HWP_CMD_MEM_WR = 4'h7;  // Memory write command.
  localparam logic [3:0] HWP_CMD_MEM_WRI = 4'hf;  // Memory write and invalidate.
  localparam int HWP_WIN_LSB = 24;  // Window base bits above a 16 Mbyte span.
  localparam int HWP_WOFF_W = 22;  // Word offset width inside the window.
  localparam logic [1:0] HWP_RGN_REG = 2'h0;  // Register region.
  localparam logic [1:0] HWP_RGN_LFB = 2'h1;  // Linear frame buffer region.
  localparam logic [1:0] HWP_RGN_TEX = 2'h2;  // Texture download region.

  // ****************************************************************
  // Installed memory masks on word offsets
  // ****************************************************************
  localparam logic [21:0] HWP_LFB_2MB = 22'h07_ffff;  // 2 Mbyte colour/depth.
  localparam logic [21:0] HWP_LFB_4MB = 22'h0f_ffff;  // 4 Mbyte colour/depth.
  localparam logic [21:0] HWP_TEX_2MB = 22'h07_ffff;  // 2 Mbyte texture.
  localparam logic [21:0] HWP_TEX_4MB = 22'h0f_ffff;  // 4 Mbyte texture.
  localparam logic [21:0] HWP_TEX_8MB = 22'h1f_ffff;  // 8 Mbyte and above.

  // ****************************************************************
  // Queue geometry
  // ****************************************************************
  localparam int HWP_AW = 7;  // On-chip queue address width.
  localparam logic [7:0] HWP_DEPTH = 8'h80;  // On-chip queue entries.
  localparam int HWP_ENT_W = 58;  // Entry: word offset, data, byte enables.
  localparam logic [16:0] HWP_TOTAL_MAX = 17'h1_0000;  // Total queued writes.
  localparam logic [16:0] HWP_OVF_MAX = HWP_TOTAL_MAX - {9'h000, HWP_DEPTH};  // Memory share.
  localparam int HWP_SYNC_N = 3;  // Pin synchroniser depth.

  // ****************************************************************
  // Bus timing against the system clock
  // ****************************************************************
  localparam int HWP_CLK_PERIOD_PS = 5000;  // System clock period.
  localparam int HWP_BUS_MAX_MHZ = 66;  // Fastest bus clock.
  localparam int HWP_BUS_MIN_CYC = (1000000 / HWP_BUS_MAX_MHZ) / HWP_CLK_PERIOD_PS;  // Rounded down.

  // Target state machine.
  typedef enum logic [1:0] {HWP_IDLE, HWP_DATA, HWP_TURN} hwp_pst_type;

endpackage

// file: hwp_ram.sv
// Two-port memory holding the on-chip posted write queue.
// Assumes the caller never reads and writes one entry in the same cycle.
`timescale 1ns/10ps
module hwp_ram #(
  parameter int W = 58,
  parameter int AW = 7
) (
  input wire logic clk_sys,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [W-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [W-1:0] rd_data_r
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [W-1:0] mem [2**AW];  // Queue entries.

  // Write port and registered read port; read data holds until the next read.
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data_r <= mem[rd_addr];
    end
  end

endmodule  // hwp_ram

// file: hwp_pci_master.sv
// Bus initiator model that drives write bursts and refused cycles into the host write port.
// Assumes target lines arrive resolved with pull-ups and calls never overlap.
`timescale 1ns/10ps
module hwp_pci_master (
  output logic pci_clk,
  output logic pci_frame_n,
  output logic pci_irdy_n,
  output logic [31:0] pci_ad,
  output logic [3:0] pci_cbe_n,
  input wire logic devsel_n,
  input wire logic trdy_n,
  input wire logic stop_n
);
  // ****************************************************************
  // Bus clock and sampling
  // ****************************************************************
  int hp = 20;  // Half bus period in ns; the clock rests high between frames.
  logic sd;  // Target select seen at the last rising bus edge.
  logic st;  // Target ready seen at the last rising bus edge.
  logic ss;  // Target stop seen at the last rising bus edge.
  initial begin
    pci_clk = 1'b1;
    pci_frame_n = 1'b1;
    pci_irdy_n = 1'b1;
    pci_ad = 32'h0000_0000;
    pci_cbe_n = 4'h0;
  end
  // One bus clock; pins change 1 ns after the sampling edge so each level lasts over 2 system clocks.
  task automatic tick();
    #(hp) pci_clk = 1'b0;
    #(hp) pci_clk = 1'b1;
    sd = devsel_n;
    st = trdy_n;
    ss = stop_n;
    #1;
  endtask
  // Linear burst: one word per beat, frame rises on the last beat, stop ends the cycle early.
  task automatic burst(input logic [31:0] addr, input logic [3:0] cmd, input int n, input logic [31:0] d0,
                       output int acc, output bit claimed, output bit stopped);
    int i;
    int wt;
    acc = 0;
    claimed = 0;
    stopped = 0;
    i = 0;
    wt = 0;
    pci_ad = addr;
    pci_cbe_n = cmd;
    pci_frame_n = 1'b0;
    tick();
    pci_ad = d0;
    pci_cbe_n = {2'b00, i[1:0]};
    pci_irdy_n = 1'b0;
    pci_frame_n = (n == 1);
    while (wt < 12) begin
      tick();
      claimed |= !sd;
      if (!sd && !st) begin
        acc++;
        i++;
        wt = 0;
        if (i == n) break;
        pci_ad = d0 + i;
        pci_cbe_n = {2'b00, i[1:0]};
        pci_frame_n = (i == n - 1);
      end else if (!sd && !ss) begin
        stopped = 1;
        if (!pci_frame_n) begin
          pci_frame_n = 1'b1;
          tick();
        end
        break;
      end else begin
        wt++;
      end
    end
    // Frame and ready are driven high; address and command lines show the inverse of their last value, never a stale copy.
    pci_frame_n = 1'b1;
    pci_irdy_n = 1'b1;
    pci_ad = ~pci_ad;
    pci_cbe_n = ~pci_cbe_n;
    tick();
    tick();
    tick();
  endtask
endmodule  // hwp_pci_master

// file: pci_host_write_port_tb.sv
// Self-checking bench for the host write port: bursts, decode, refusals and queue stalls.
// Assumes the bus initiator model and a behavioural overflow memory beside the design.
`timescale 1ns/10ps
module pci_host_write_port_tb;
  import hwp_pkg::*;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic pci_clk, pci_frame_n, pci_irdy_n;
  logic [31:0] pci_ad;
  logic [3:0] pci_cbe_n;
  logic pci_devsel_n_o, pci_devsel_oe, pci_trdy_n_o, pci_trdy_oe, pci_stop_n_o, pci_stop_oe;
  logic [7:0] win_base = 8'ha5;
  logic lfb_via_pipe = 1'b0;
  logic [3:0] lfb_fmt = 4'h0;
  logic fb_4mb = 1'b0;
  logic [1:0] tex_size = 2'h0;
  logic ovf_en = 1'b0;
  logic [16:0] ovf_depth = 17'h0_0010;
  logic out_ready = 1'b1;
  logic out_valid, out_to_pipe, spill_valid, fill_req;
  logic [1:0] out_region;
  logic [21:0] out_addr;
  logic [31:0] out_data;
  logic [3:0] out_be, out_lfb_fmt;
  logic spill_ready = 1'b0;
  logic fill_valid = 1'b0;
  logic [15:0] spill_index, fill_index, fill_idx;
  logic [57:0] spill_data;
  logic [57:0] fill_data = 58'h0;
  logic [57:0] ovf_mem [0:65535];
  logic [60:0] exp_q[$];
  int fill_wait = 0;
  int cyc = 0;
  int error_cnt = 0;
  int total_checks = 0;
  wire devsel_n = pci_devsel_oe ? pci_devsel_n_o : 1'b1;
  wire trdy_n = pci_trdy_oe ? pci_trdy_n_o : 1'b1;
  wire stop_n = pci_stop_oe ? pci_stop_n_o : 1'b1;
  initial forever #2.5 clk_sys = ~clk_sys;
  hwp_pci_master hwp_pci_master_i (.pci_clk(pci_clk), .pci_frame_n(pci_frame_n), .pci_irdy_n(pci_irdy_n),
    .pci_ad(pci_ad), .pci_cbe_n(pci_cbe_n), .devsel_n(devsel_n), .trdy_n(trdy_n), .stop_n(stop_n));
  hwp_top hwp_top_i (.clk_sys(clk_sys), .srst(srst), .pci_clk(pci_clk), .pci_frame_n(pci_frame_n),
    .pci_irdy_n(pci_irdy_n), .pci_ad(pci_ad), .pci_cbe_n(pci_cbe_n), .pci_devsel_n_o(pci_devsel_n_o),
    .pci_devsel_oe(pci_devsel_oe), .pci_trdy_n_o(pci_trdy_n_o), .pci_trdy_oe(pci_trdy_oe),
    .pci_stop_n_o(pci_stop_n_o), .pci_stop_oe(pci_stop_oe), .win_base(win_base), .lfb_via_pipe(lfb_via_pipe),
    .lfb_fmt(lfb_fmt), .fb_4mb(fb_4mb), .tex_size(tex_size), .ovf_en(ovf_en), .ovf_depth(ovf_depth),
    .out_valid(out_valid), .out_ready(out_ready), .out_region(out_region), .out_addr(out_addr),
    .out_data(out_data), .out_be(out_be), .out_to_pipe(out_to_pipe), .out_lfb_fmt(out_lfb_fmt),
    .spill_valid(spill_valid), .spill_ready(spill_ready), .spill_index(spill_index), .spill_data(spill_data),
    .fill_req(fill_req), .fill_index(fill_index), .fill_valid(fill_valid), .fill_data(fill_data));
  // Overflow memory: accepts a spill every other cycle, answers a fill four cycles after the request.
  always @(posedge clk_sys) begin
    spill_ready <= ~spill_ready;
    if (spill_valid && spill_ready) ovf_mem[spill_index] <= spill_data;
    fill_valid <= 1'b0;
    fill_data <= ~fill_data;
    if (fill_req) begin
      fill_idx <= fill_index;
      fill_wait <= 3;
    end else if (fill_wait == 1) begin
      fill_valid <= 1'b1;
      fill_data <= ovf_mem[fill_idx];
      fill_wait <= 0;
    end else if (fill_wait > 1) fill_wait <= fill_wait - 1;
  end
  // Output sink compares every word moved against the expected queue, in order.
  always @(posedge clk_sys) begin
    if (out_valid === 1'b1 && out_ready) begin
      if (exp_q.size() == 0) check(1, 0, "unexpected output word");
      else check({out_to_pipe, out_region, out_addr, out_data, out_be}, exp_q.pop_front(), "word");
      check(out_lfb_fmt, lfb_fmt, "pixel format");
    end
  end
  // Cycle ceiling that cuts a hang short.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      error_cnt++;
      final_report();
    end
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  // Expected word per beat: region from offset bits, offset cut to the installed memory size.
  task automatic push_exp(input logic [31:0] addr, input int n, input logic [31:0] d0);
    logic [21:0] w;
    logic [21:0] m;
    logic [1:0] rg;
    for (int i = 0; i < n; i++) begin
      w = addr[23:2] + 22'(i);
      rg = (w[21:20] == 2'h0) ? HWP_RGN_REG : (w[21:20] == 2'h1) ? HWP_RGN_LFB : HWP_RGN_TEX;
      m = (rg == HWP_RGN_REG) ? 22'h0f_ffff : (rg == HWP_RGN_LFB) ? (fb_4mb ? HWP_LFB_4MB : HWP_LFB_2MB) :
          (tex_size == 2'h0) ? HWP_TEX_2MB : (tex_size == 2'h1) ? HWP_TEX_4MB : HWP_TEX_8MB;
      m = m | ((rg == HWP_RGN_TEX) ? 22'h20_0000 : 22'h30_0000);  // Region bits stay in the offset.
      exp_q.push_back({lfb_via_pipe && rg == HWP_RGN_LFB, rg, w & m, 32'(d0 + i), ~{2'b00, 2'(i)}});
    end
  endtask
  task automatic run(input logic [31:0] addr, input logic [3:0] cmd, input int n, input bit full,
                     output int acc, output bit st);
    bit cl;
    bit cl_exp;
    cl_exp = (addr[31:24] == win_base) && (cmd == HWP_CMD_MEM_WR || cmd == HWP_CMD_MEM_WRI);
    if (cl_exp) push_exp(addr, n, addr ^ 32'h5a5a_0000);
    hwp_pci_master_i.burst(addr, cmd, n, addr ^ 32'h5a5a_0000, acc, cl, st);
    for (int i = acc; cl_exp && i < n; i++) void'(exp_q.pop_back());
    check(cl, cl_exp, "claim");
    if (full && cl_exp) check(acc, n, "beats taken");
    check({pci_devsel_oe, pci_trdy_oe, pci_stop_oe}, 0, "pins released");
  endtask
  task automatic drain();
    @(posedge clk_sys);
    out_ready <= 1'b1;
    for (int w = 0; w < 6000 && exp_q.size() != 0; w++) @(posedge clk_sys);
    check(exp_q.size(), 0, "words lost");
  endtask
  task automatic t_regions();
    int a;
    bit s;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_sys);
      fb_4mb <= k[0];
      tex_size <= 2'(k);
      lfb_via_pipe <= ~k[0];
      lfb_fmt <= 4'(k + 3);
      @(posedge clk_sys);
      run({win_base, 24'h00_0010}, HWP_CMD_MEM_WR, 3, 1, a, s);
      run({win_base, 24'h60_0004}, HWP_CMD_MEM_WRI, 3, 1, a, s);
      run({win_base, 24'hf0_0008}, HWP_CMD_MEM_WR, 3, 1, a, s);
      drain();
    end
    $display("test regions done");
  endtask
  task automatic t_refuse();
    int a;
    bit s;
    logic [3:0] cmds [4] = '{4'h6, 4'h3, 4'h2, 4'hb};
    foreach (cmds[i]) run({win_base, 24'h00_0020}, cmds[i], 2, 0, a, s);
    run({win_base + 8'h01, 24'h00_0000}, HWP_CMD_MEM_WR, 2, 0, a, s);
    run({win_base - 8'h01, 24'hff_fffc}, HWP_CMD_MEM_WR, 2, 0, a, s);
    drain();
    $display("test refuse done");
  endtask
  task automatic t_fast();
    int a;
    bit s;
    hwp_pci_master_i.hp = 11;
    run({win_base, 24'h40_0100}, HWP_CMD_MEM_WR, 16, 1, a, s);
    check(s, 0, "no stop in zero-wait burst");
    hwp_pci_master_i.hp = 20;
    drain();
    $display("test fast done");
  endtask
  task automatic t_stall();
    int a;
    bit s;
    int lo;
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_sys);
      ovf_en <= k[0];
      out_ready <= 1'b0;
      @(posedge clk_sys);
      lo = 128 + 16 * k;
      run({win_base, 24'h80_0000}, HWP_CMD_MEM_WR, 200, 0, a, s);
      check(s, 1, "stop when full");
      check(a >= lo && a <= lo + 3, 1, "queue depth");
      drain();
    end
    $display("test stall done");
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    t_regions();
    t_refuse();
    t_fast();
    t_stall();
    final_report();
  end
endmodule  // pci_host_write_port_tb
